// >>> rtl/sqs_params.svh
// Constants for the sequencer stack entry bank: offsets, fields, resets.
// Assumes inclusion by bare name from the rtl/ folder.
`ifndef SQS_PARAMS_SVH
`define SQS_PARAMS_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define SQS_IDX_STEP20     8'h34
`define SQS_IDX_STEP21     8'h35
`define SQS_IDX_STEP22     8'h36
`define SQS_IDX_POS        8'h40
`define SQS_ADDR_STEP20    12'h0D0
`define SQS_ADDR_STEP21    12'h0D4
`define SQS_ADDR_STEP22    12'h0D8
`define SQS_ADDR_POS       12'h100

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SQS_BIT_DIR        15
`define SQS_ADDR_HI        14
`define SQS_ADDR_LO        9
`define SQS_BIT_RET        8
`define SQS_CHB_HI         7
`define SQS_CHB_LO         4
`define SQS_CHA_HI         3
`define SQS_CHA_LO         0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SQS_RST_STEP20     16'h6800
`define SQS_RST_STEP21     16'h6A00
`define SQS_RST_STEP22     16'h6C00

`endif

// >>> rtl/sqs_pkg.sv
// Types shared by the sequencer stack entry bank.
// Assumes sqs_params.svh holds the numeric constants.
package sqs_pkg;
  typedef logic [15:0] sqs_word_t;   // One stack entry
  typedef logic [1:0]  sqs_ptr_t;    // Active entry index 0..2
  typedef enum logic [0:0] {
    SQS_IDLE,
    SQS_ACCESS
  } sqs_bus_t;                       // APB slave phase
  typedef struct packed {
    sqs_word_t [2:0] step;           // Entries twenty to twenty-two
    sqs_ptr_t        ptr;            // Active entry
    sqs_bus_t        bus;            // Bus phase
    logic            pready;         // Answer strobe
    logic            pslverr;        // Unmapped answer
    logic [31:0]     prdata;         // Read data
    logic [3:0]      cha;            // Applied channel A
    logic [3:0]      chb;            // Applied channel B
    logic            applied;        // Selection valid pulse
  } sqs_state_t;
endpackage

// >>> rtl/sqs_bank.sv
// Sequencer stack entries twenty to twenty-two with an APB slave and a
// small walker that applies each entry's channel pair per conversion.
// Assumes a single clock; conversion done arrives synchronous to it.
//
// How it works
// - Bit 15 stores read or write direction
// - Bits 14:9 store entry's own address
// - Entry twenty at 0x34, resets 0x6800
// - Entry twenty-one at 0x35, resets 0x6A00
// - Entry twenty-two at 0x36, resets 0x6C00
// - Return bit clear: advance after conversion
// - Return bit set: go to first
// - Bits 7:4 select converter B channel
// - Bits 3:0 select converter A channel
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "sqs_params.svh"

module sqs_bank (
  input  wire logic            clk_in,            // 10 MHz clock
  input  wire logic            rst_n_in,          // Sync reset, low
  input  wire logic            clk_en_in,         // Freezes all state but the valid pulse when low
  input  wire logic            psel_in,           // APB select
  input  wire logic            penable_in,        // APB enable
  input  wire logic            pwrite_in,         // APB direction
  input  wire logic [11:0]     paddr_in,          // APB byte address
  input  wire logic [31:0]     pwdata_in,         // APB write data
  input  wire logic [3:0]      pstrb_in,          // APB byte strobes
  input  wire logic            conv_done_in,      // Conversion completed pulse
  output logic                 pready_out,        // APB ready
  output logic                 pslverr_out,       // APB error
  output logic [31:0]          prdata_out,        // APB read data
  output logic [3:0]           converter_a_channel_select_out, // Channel A
  output logic [3:0]           converter_b_channel_select_out, // Channel B
  output logic                 select_valid_out,  // New pair pulse
  output var sqs_pkg::sqs_ptr_t active_entry_out  // Active entry index
);
  import sqs_pkg::*;

  // ----------------------------------------
  // Usage notes
  // ----------------------------------------
  // Register map, one aligned word per entry:
  //   0x0D0  entry twenty
  //   0x0D4  entry twenty-one
  //   0x0D8  entry twenty-two
  //   0x100  active entry index, read only, writes ignored
  // Any other address answers with an error and reads zero.
  // Upper half of every read word is zero.
  // Byte strobes 0 and 1 select the two halves of an entry;
  // strobes 2 and 3 have nothing to land on and are ignored.
  //
  // Bus timing: every transfer takes exactly one wait state.
  //   Setup edge      bus moves to access
  //   First access    answer computed, ready raised
  //   Second access   ready seen, transfer completes
  // A setup cycle may follow the completing edge at once.
  //
  // Entries are plain storage. The direction bit and the own
  // address field are kept as written and never decoded here;
  // the far serial or parallel front end owns that meaning.
  // Trade-off: keeps this bank small, but a host that writes a
  // wrong own address will still see its word stored.
  //
  // Walker: entries are visited in order and wrap after the
  // last one. A set return bit on the active entry sends the
  // walker back to the first entry instead. The channel pair
  // applied is that of the entry moved to, so both converters
  // always switch on the same edge.
  //
  // Limitation: a write to the entry being moved to in the
  // very cycle of a conversion boundary applies the old pair;
  // the new pair takes effect on the next visit.
  //
  // Clock enable low freezes every flop, bus and walker alike, except the
  // select valid pulse, which clears; reset still acts, so a stalled bank can always be cleared.

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Address to entry index, 3 when not an entry
  function automatic logic [1:0] entry_of(input logic [11:0] a);
    if (a == `SQS_ADDR_STEP20) begin
      entry_of = 2'h0;
    end else if (a == `SQS_ADDR_STEP21) begin
      entry_of = 2'h1;
    end else if (a == `SQS_ADDR_STEP22) begin
      entry_of = 2'h2;
    end else begin
      entry_of = 2'h3;
    end
  endfunction

  // Byte-lane merge of a 16-bit entry
  function automatic sqs_word_t merge(input sqs_word_t old,
                                      input logic [31:0] wd,
                                      input logic [3:0] st);
    merge = old;
    if (st[0]) begin
      merge[7:0] = wd[7:0];
    end
    if (st[1]) begin
      merge[15:8] = wd[15:8];
    end
  endfunction

  sqs_state_t st;       // Registered state
  sqs_state_t next_st;  // Next state
  logic [1:0] hit;      // Decoded entry
  logic       setup;    // Setup cycle seen
  sqs_word_t  cur;      // Active entry word
  logic [7:0] pair_next; // Channel pair of the entry walked to

  assign hit   = entry_of(paddr_in);
  assign setup = psel_in && !penable_in;
  assign cur   = st.step[st.ptr];
  // Used by the checks only: pair the walker is about to apply
  assign pair_next = st.step[next_st.ptr][7:0];

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.applied = 1'b0;
    if (!rst_n_in) begin
      next_st.step[0] = `SQS_RST_STEP20;
      next_st.step[1] = `SQS_RST_STEP21;
      next_st.step[2] = `SQS_RST_STEP22;
      next_st.ptr     = 2'h0;
      next_st.bus     = SQS_IDLE;
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
      next_st.prdata  = 32'h0000_0000;
      next_st.cha     = 4'h0;
      next_st.chb     = 4'h0;
    end else if (clk_en_in) begin
      // Bus: one wait state, answer in the second access cycle
      case (st.bus)
        SQS_IDLE: begin
          next_st.pready = 1'b0;
          if (setup) begin
            next_st.bus = SQS_ACCESS;
          end
        end
        SQS_ACCESS: begin
          if (st.pready) begin
            // Handshake completes this edge
            next_st.pready  = 1'b0;
            next_st.pslverr = 1'b0;
            next_st.bus     = SQS_IDLE;
          end else if (psel_in && penable_in) begin
            next_st.pready = 1'b1;
            if (hit == 2'h3 && paddr_in != `SQS_ADDR_POS) begin
              // Unmapped: error, reads zero, no write
              next_st.pslverr = 1'b1;
              next_st.prdata  = 32'h0000_0000;
            end else if (pwrite_in) begin
              // Direction, address, return, channels stored whole
              if (hit != 2'h3) begin
                next_st.step[hit] = merge(st.step[hit], pwdata_in,
                                          pstrb_in);
              end
            end else if (hit != 2'h3) begin
              next_st.prdata = {16'h0000, st.step[hit]};
            end else begin
              next_st.prdata = {30'h0000_0000, st.ptr};
            end
          end else begin
            next_st.bus = SQS_IDLE;
          end
        end
        default: begin
          next_st.bus = SQS_IDLE;
        end
      endcase
      // Walker: pick next entry at a conversion boundary
      if (conv_done_in) begin
        if (cur[`SQS_BIT_RET] || st.ptr == 2'h2) begin
          next_st.ptr = 2'h0;
        end else begin
          next_st.ptr = st.ptr + 2'h1;
        end
        next_st.applied = 1'b1;
        next_st.cha = st.step[next_st.ptr][`SQS_CHA_HI:`SQS_CHA_LO];
        next_st.chb = st.step[next_st.ptr][`SQS_CHB_HI:`SQS_CHB_LO];
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    st <= next_st;
  end

  // Outputs straight from flip-flops
  assign pready_out  = st.pready;
  assign pslverr_out = st.pslverr;
  assign prdata_out  = st.prdata;
  assign converter_a_channel_select_out = st.cha;
  assign converter_b_channel_select_out = st.chb;
  assign select_valid_out = st.applied;
  assign active_entry_out = st.ptr;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_reset_twenty: assert property (@(posedge clk_in)
    !rst_n_in |=> st.step[0] == 16'h6800)
    else $error("entry twenty reset wrong");
  a_reset_twentyone: assert property (@(posedge clk_in)
    !rst_n_in |=> st.step[1] == 16'h6A00)
    else $error("entry twenty-one reset wrong");
  a_reset_twentytwo: assert property (@(posedge clk_in)
    !rst_n_in |=> st.step[2] == 16'h6C00)
    else $error("entry twenty-two reset wrong");
  a_step_advance: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clk_en_in && conv_done_in && !cur[8] && st.ptr < 2'h2
    |=> st.ptr == $past(st.ptr) + 2'h1)
    else $error("walker failed to advance");
  a_step_return: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clk_en_in && conv_done_in && cur[8] |=> st.ptr == 2'h0)
    else $error("walker failed to return");
  // Both halves of the pair must come from the same entry
  a_pair_applied: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clk_en_in && conv_done_in
    |=> st.applied && {st.chb, st.cha} == $past(pair_next))
    else $error("channel pair not from entry moved to");
  a_write_full: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clk_en_in && st.bus == SQS_ACCESS && !st.pready && psel_in && penable_in
    && pwrite_in && paddr_in == `SQS_ADDR_STEP20 && pstrb_in[1:0] == 2'b11
    |=> st.step[0] == $past(pwdata_in[15:0]))
    else $error("entry write lost");
  // Refused writes must leave every entry alone
  a_unmapped_keep: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clk_en_in && st.bus == SQS_ACCESS && !st.pready && psel_in && penable_in
    && pwrite_in && hit == 2'h3
    |=> st.step == $past(st.step))
    else $error("refused write changed an entry");
  // Ready output lasts one enabled cycle
  a_ready_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clk_en_in && st.pready |=> !st.pready)
    else $error("ready held too long");
  a_error_ready: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    st.pslverr |-> st.pready)
    else $error("error without ready");
  a_valid_cause: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    st.applied |-> $past(conv_done_in && clk_en_in))
    else $error("pair pulse without conversion");
  // Only three entries exist
  a_ptr_range: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    st.ptr != 2'h3)
    else $error("active entry out of range");
  a_ready_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clk_en_in && setup ##1 clk_en_in && psel_in && penable_in |=> st.pready)
    else $error("bus answer late");
endmodule
`default_nettype wire

// >>> verif/sqs_conv_src.sv
// Stand-in for the converter core: answers a start with one done pulse.
// Assumes the bank's clock; start is a one-cycle request.
`timescale 1ns/10ps
`default_nettype none
module sqs_conv_src #(parameter int CONV_CYC = 5) (
  input  wire logic clk_in,   // Bank clock
  input  wire logic start_in, // Conversion start
  output logic      done_out  // One-cycle completion
);
  int cnt = 0;                // Cycles left in conversion
  initial done_out = 1'b0;
  // Slow on purpose: done never arrives in the start's own cycle
  always @(posedge clk_in) begin
    done_out <= (cnt == 1);
    if (start_in) cnt <= CONV_CYC;
    else if (cnt != 0) cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the stack entry bank, with a reference model.
// Assumes the conversion source model and the bank's package.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
  import sqs_pkg::*;
  logic clk_in = 0, rst_n_in = 0, psel = 0, pen = 0, pwr = 0, start = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, wd, seed = 32'hAC94793C;
  logic pready, pslverr, done, sv, e;
  logic [3:0] cha, chb;
  sqs_ptr_t ptr;
  sqs_word_t m [3];           // Reference copy of the entries
  int mismatches = 0, n_tests = 0, p = 0, i;
  always #50 clk_in = ~clk_in;
  sqs_bank uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .pstrb_in(4'h3), .conv_done_in(done),
    .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
    .converter_a_channel_select_out(cha), .converter_b_channel_select_out(chb),
    .select_valid_out(sv), .active_entry_out(ptr));
  sqs_conv_src conv (.clk_in(clk_in), .start_in(start), .done_out(done));
  // ----------------------------------------
  // Verdict, bus and conversion tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer; an edge passes first so psel never toggles twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_in);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    k = 0;
    do begin @(posedge clk_in); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin mismatches++; tally_and_finish(); end
    r = prdata; e = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  // One conversion; the model walks the stack the same way
  task automatic conv_step();
    int k;
    start <= 1'b1;
    @(posedge clk_in);
    start <= 1'b0;
    k = 0;
    do begin @(posedge clk_in); k++; end while (done !== 1'b1 && k < 50);
    if (k >= 50) begin mismatches++; tally_and_finish(); end
    p = m[p][8] ? 0 : (p == 2 ? 0 : p + 1);
    @(posedge clk_in);
    `CHK("select_valid", 1'b1, sv)
    `CHK("active_entry", p[1:0], ptr)
    `CHK("chan_a", m[p][3:0], cha)
    `CHK("chan_b", m[p][7:4], chb)
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    m[0] = 16'h6800;
    m[1] = 16'h6A00;
    m[2] = 16'h6C00;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (i = 0; i < 3; i++) begin
      apb(1'b0, 12'h0D0 + 12'(4 * i), 32'h0);
      `CHK("reset_value", {16'h0, m[i]}, r)
    end
    // Random words, return bit clear on the first two entries
    for (i = 0; i < 3; i++) begin
      wd = $random(seed);
      if (i < 2) wd[8] = 1'b0;
      m[i] = wd[15:0];
      apb(1'b1, 12'h0D0 + 12'(4 * i), wd);
      apb(1'b0, 12'h0D0 + 12'(4 * i), 32'h0);
      `CHK("readback", {16'h0, m[i]}, r)
      `CHK("readback_err", 1'b0, e)
    end
    // Unmapped word just past the last entry must be refused
    apb(1'b0, 12'h0DC, 32'h0);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_data", 32'h0, r)
    for (i = 0; i < 4; i++) conv_step();
    // Active entry index is readable at its own word
    apb(1'b0, 12'h100, 32'h0);
    `CHK("active_read", {30'h0, p[1:0]}, r)
    // Return bit on a middle entry sends the walker back to the first
    m[p][8] = 1'b1;
    apb(1'b1, 12'h0D0 + 12'(4 * p), {16'h0, m[p]});
    conv_step();
    tally_and_finish();
  end
endmodule
`default_nettype wire
